// ==== core/scfc_defines.svh ====
// Purpose: named constants for the supply command and fault controller
// Assumes: 25 MHz system clock
// Notes: qualification times are kept in ms and their cycle counts derive from them; soft start is given in cycles
`ifndef SCFC_DEFINES_SVH
`define SCFC_DEFINES_SVH

`define SCFC_CLK_HZ 25000000
`define SCFC_OVT_QUAL_MS 30
`define SCFC_OCT_QUAL_MS 60
`define SCFC_OVT_QUAL_CYC ((`SCFC_CLK_HZ / 1000) * `SCFC_OVT_QUAL_MS)
`define SCFC_OCT_QUAL_CYC ((`SCFC_CLK_HZ / 1000) * `SCFC_OCT_QUAL_MS)
`define SCFC_SOFT_START_CYC 250000
`define SCFC_CNT_W 21
`define SCFC_LVL_W 12
`define SCFC_LIMIT_PCT 110
`define SCFC_PHASE_PCT 10
`define SCFC_PCT_FULL 100
`define SCFC_FULL_SCALE 12'h8ba
`define SCFC_RATED_LINE 12'hc00

`endif

// ==== core/scfc_pkg.sv ====
// Purpose: types shared by the supply command and fault controller
// Assumes: scfc_defines.svh supplies all figures
// Notes: fault vector order is fixed and used for status and alarm outputs
package scfc_pkg;

	typedef enum logic [1:0]
	{
		ST_STANDBY = 2'b00,
		ST_SOFT_START = 2'b01,
		ST_POWERED = 2'b10,
		ST_ALARM = 2'b11
	} scfc_state_e;

	// one command strobe set per interface
	typedef struct packed
	{
		logic start;
		logic stop;
		logic clear;
	} scfc_cmd_s;

	// latched fault flags
	typedef struct packed
	{
		logic overVoltageTrip;
		logic overCurrentTrip;
		logic thermalFault;
		logic safetyInterlockFault;
		logic phaseLossFault;
	} scfc_fault_s;

endpackage : scfc_pkg

// ==== core/scfc_supply_ctrl.sv ====
// Purpose: command state machine and fault latching for a programmable dc supply
// Assumes: one 25 MHz clock; pin-level inputs arrive asynchronously
// Notes: measured levels and thresholds are 12-bit codes; full scale is SCFC_FULL_SCALE
//
// What this block does
// - start acts only from standby
// - start closes contactor, soft start, then powered
// - stop acts only in soft start or powered, opens contactor
// - active stop overrides a start command; a clear still acts
// - clear releases fault only when condition gone
// - latched fault blocks operation until clear
// - over-voltage must persist 30 ms to trip
// - voltage threshold clamped to 110 percent, default
// - over-voltage trip opens contactor, flags alarm
// - over-current must persist 60 ms to trip
// - current threshold clamped to 110 percent, default
// - over-current trip opens contactor, flags alarm
// - thermal switch opens contactor, blocks enable, alarms
// - enabled interlock requires high level to operate
// - interlock break switches dissipative elements off fast
// - phase A below 10 percent trips phase loss
// - phase loss blocks enabling per operating state
// - front panel commands need local enable
// - remote commands need remote enable
`include "scfc_defines.svh"
module scfc_supply_ctrl
	import scfc_pkg::*;
#(
	parameter int SoftStartCycles = `SCFC_SOFT_START_CYC,
	parameter int OvtQualCycles = `SCFC_OVT_QUAL_CYC,
	parameter int OctQualCycles = `SCFC_OCT_QUAL_CYC
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire scfc_cmd_s panelCmd,
	input wire scfc_cmd_s extIoCmd,
	input wire scfc_cmd_s hostCmd,
	input wire logic localCommandEnable,
	input wire logic remoteCommandEnable,
	input wire logic interlockEnable,
	input wire logic interlockLevel,
	input wire logic thermalSwitchOk,
	input wire logic [`SCFC_LVL_W-1:0] phaseALevel,
	input wire logic [`SCFC_LVL_W-1:0] outVoltage,
	input wire logic [`SCFC_LVL_W-1:0] outCurrent,
	input wire logic ovtSetValid,
	input wire logic [`SCFC_LVL_W-1:0] ovtSetValue,
	input wire logic octSetValid,
	input wire logic [`SCFC_LVL_W-1:0] octSetValue,
	output logic contactorClosed,
	output logic softStartActive,
	output logic powered,
	output logic standby,
	output logic alarm,
	output logic dissipativeOff,
	output scfc_fault_s faultStatus,
	output scfc_fault_s alarmOut,
	output logic [`SCFC_LVL_W-1:0] ovtThreshold,
	output logic [`SCFC_LVL_W-1:0] octThreshold
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------

	// clamp a requested threshold to the 110 percent ceiling
	function automatic logic [`SCFC_LVL_W-1:0] clampLimit(input logic [`SCFC_LVL_W-1:0] v);
		logic [`SCFC_LVL_W-1:0] lim;
		lim = `SCFC_LVL_W'((32'(`SCFC_FULL_SCALE) * `SCFC_LIMIT_PCT) / `SCFC_PCT_FULL);
		clampLimit = (v > lim) ? lim : v;
	endfunction : clampLimit

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	localparam int SyncW = 9 + 3 * `SCFC_LVL_W + 5;
	// reset shows healthy levels, so no false thermal or phase fault follows reset
	localparam logic [SyncW-1:0] SyncIdle = {9'h000, 5'h01, {`SCFC_LVL_W{1'b1}},
		{(2 * `SCFC_LVL_W){1'b0}}};
	logic [SyncW-1:0] sync1_q;
	logic [SyncW-1:0] sync2_q;
	wire logic [SyncW-1:0] rawIn = {panelCmd, extIoCmd, hostCmd, localCommandEnable,
		remoteCommandEnable, interlockEnable, interlockLevel, thermalSwitchOk,
		phaseALevel, outVoltage, outCurrent};

	// two flops on every pin-level input; only the second stage is read
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_q <= SyncIdle;
			sync2_q <= SyncIdle;
		end
		else
		begin
			sync1_q <= rawIn;
			sync2_q <= sync1_q;
		end
	end

	scfc_cmd_s sPanel;
	scfc_cmd_s sExt;
	scfc_cmd_s sHost;
	logic sLocalEn;
	logic sRemoteEn;
	logic sIlkEn;
	logic sIlkLevel;
	logic sThermOk;
	logic [`SCFC_LVL_W-1:0] sPhase;
	logic [`SCFC_LVL_W-1:0] sVolt;
	logic [`SCFC_LVL_W-1:0] sCurr;
	assign {sPanel, sExt, sHost, sLocalEn, sRemoteEn, sIlkEn, sIlkLevel, sThermOk,
		sPhase, sVolt, sCurr} = sync2_q;

	// ---------------------------------------------------------------
	// command gating
	// ---------------------------------------------------------------
	logic panelOk;
	logic remoteOk;
	logic stopReq;
	logic clearReq;

	// each interface counts only while its enable is on
	assign panelOk = sLocalEn;
	assign remoteOk = sRemoteEn;
	assign stopReq = (panelOk & sPanel.stop) | (remoteOk & (sExt.stop | sHost.stop));
	assign clearReq = (panelOk & sPanel.clear) | (remoteOk & (sExt.clear | sHost.clear));

	// ---------------------------------------------------------------
	// thresholds
	// ---------------------------------------------------------------
	logic [`SCFC_LVL_W-1:0] ovtThr_q;
	logic [`SCFC_LVL_W-1:0] octThr_q;
	logic ovtStrobe_q;
	logic octStrobe_q;
	logic [`SCFC_LVL_W-1:0] ovtVal_q;
	logic [`SCFC_LVL_W-1:0] octVal_q;

	// settings arrive from other logic on this clock; registered once before use
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ovtStrobe_q <= 1'b0;
			octStrobe_q <= 1'b0;
			ovtVal_q <= '0;
			octVal_q <= '0;
		end
		else
		begin
			ovtStrobe_q <= ovtSetValid;
			octStrobe_q <= octSetValid;
			ovtVal_q <= ovtSetValue;
			octVal_q <= octSetValue;
		end
	end

	// default is the ceiling; writes above it are clamped
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ovtThr_q <= clampLimit({`SCFC_LVL_W{1'b1}});
			octThr_q <= clampLimit({`SCFC_LVL_W{1'b1}});
		end
		else
		begin
			if (ovtStrobe_q)
				ovtThr_q <= clampLimit(ovtVal_q);
			if (octStrobe_q)
				octThr_q <= clampLimit(octVal_q);
		end
	end

	// ---------------------------------------------------------------
	// fault conditions and qualification
	// ---------------------------------------------------------------
	logic ovCond;
	logic ocCond;
	logic thCond;
	logic ilCond;
	logic phCond;
	logic [`SCFC_LVL_W-1:0] phaseMin;
	logic [`SCFC_CNT_W-1:0] ovCnt_q;
	logic [`SCFC_CNT_W-1:0] ocCnt_q;
	logic ovHit;
	logic ocHit;

	assign phaseMin = `SCFC_LVL_W'((32'(`SCFC_RATED_LINE) * `SCFC_PHASE_PCT) / `SCFC_PCT_FULL);
	assign ovCond = sVolt > ovtThr_q;
	assign ocCond = sCurr > octThr_q;
	assign thCond = !sThermOk;
	assign ilCond = sIlkEn & !sIlkLevel;
	assign phCond = sPhase < phaseMin;
	assign ovHit = ovCond && (ovCnt_q == `SCFC_CNT_W'(OvtQualCycles - 1));
	assign ocHit = ocCond && (ocCnt_q == `SCFC_CNT_W'(OctQualCycles - 1));

	// counters run only while the condition holds and restart from zero otherwise
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ovCnt_q <= '0;
			ocCnt_q <= '0;
		end
		else
		begin
			if (!ovCond)
				ovCnt_q <= '0;
			else if (!ovHit)
				ovCnt_q <= ovCnt_q + 1'b1;
			if (!ocCond)
				ocCnt_q <= '0;
			else if (!ocHit)
				ocCnt_q <= ocCnt_q + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// fault latches
	// ---------------------------------------------------------------
	scfc_fault_s fault_q;
	scfc_fault_s faultSet;
	scfc_fault_s faultLive;
	scfc_state_e state_q;
	logic clearOk;

	assign faultSet = '{ovHit, ocHit, thCond, ilCond, phCond};
	// a live level blocks the clear, including a trip comparator that is still counting
	assign faultLive = '{ovCond, ocCond, thCond, ilCond, phCond};
	assign clearOk = clearReq && (faultLive == '0);

	// set wins over clear so an event in the clear cycle is kept
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			fault_q <= '0;
		else if (clearOk)
			fault_q <= faultSet;
		else
			fault_q <= fault_q | faultSet;
	end

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	logic [`SCFC_CNT_W-1:0] softCnt_q;
	logic anyFault;
	logic startOk;
	logic softDone;

	assign anyFault = (fault_q != '0) || (faultSet != '0);
	// host start is not masked by phase loss, but anyFault sends standby to alarm before a start is taken
	assign startOk = ((panelOk & sPanel.start & !fault_q.phaseLossFault) |
		(remoteOk & sExt.start & !fault_q.phaseLossFault) |
		(remoteOk & sHost.start)) & !stopReq;
	assign softDone = softCnt_q == `SCFC_CNT_W'(SoftStartCycles - 1);

	// fault wins over everything, stop over start
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			state_q <= ST_STANDBY;
		else
			unique case (state_q)
				ST_STANDBY:
				begin
					if (anyFault)
						state_q <= ST_ALARM;
					else if (startOk)
						state_q <= ST_SOFT_START;
				end
				ST_SOFT_START:
				begin
					if (anyFault)
						state_q <= ST_ALARM;
					else if (stopReq)
						state_q <= ST_STANDBY;
					else if (softDone)
						state_q <= ST_POWERED;
				end
				ST_POWERED:
				begin
					if (anyFault)
						state_q <= ST_ALARM;
					else if (stopReq)
						state_q <= ST_STANDBY;
				end
				ST_ALARM:
				begin
					if (clearOk && faultSet == '0)
						state_q <= ST_STANDBY;
				end
			endcase
	end

	// soft start length counted only inside its own state
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			softCnt_q <= '0;
		else if (state_q == ST_SOFT_START && !softDone)
			softCnt_q <= softCnt_q + 1'b1;
		else if (state_q != ST_SOFT_START)
			softCnt_q <= '0;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// all outputs registered from the current state, flags, thresholds and the live interlock condition; one cycle behind them
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			contactorClosed <= 1'b0;
			softStartActive <= 1'b0;
			powered <= 1'b0;
			standby <= 1'b1;
			alarm <= 1'b0;
			dissipativeOff <= 1'b0;
			faultStatus <= '0;
			alarmOut <= '0;
			ovtThreshold <= '0;
			octThreshold <= '0;
		end
		else
		begin
			contactorClosed <= (state_q == ST_SOFT_START) || (state_q == ST_POWERED);
			softStartActive <= state_q == ST_SOFT_START;
			powered <= state_q == ST_POWERED;
			standby <= state_q == ST_STANDBY;
			alarm <= state_q == ST_ALARM;
			dissipativeOff <= fault_q.safetyInterlockFault | ilCond;
			faultStatus <= fault_q;
			alarmOut <= fault_q;
			ovtThreshold <= ovtThr_q;
			octThreshold <= octThr_q;
		end
	end

endmodule : scfc_supply_ctrl

// ==== verification/scfc_operator_model.sv ====
// Purpose: operator side that drives the three command interfaces
// Assumes: the bench raises go for one cycle just after an edge
// Notes: a command stands HoldCycles cycles, then its lines idle low
module scfc_operator_model
	import scfc_pkg::*;
#(
	parameter int HoldCycles = 3
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic go,
	input wire logic [1:0] src,
	input wire scfc_cmd_s req,
	output scfc_cmd_s panelCmd,
	output scfc_cmd_s extIoCmd,
	output scfc_cmd_s hostCmd
);
	int holdLeft_q;
	logic [1:0] srcSel_q;
	scfc_cmd_s reqHeld_q;

	// a level held for several cycles survives the two-flop synchroniser
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			holdLeft_q <= 0;
		else if (go)
		begin
			holdLeft_q <= HoldCycles;
			srcSel_q <= src;
			reqHeld_q <= req;
		end
		else if (holdLeft_q > 0)
			holdLeft_q <= holdLeft_q - 1;

	// only the chosen interface carries the request
	assign panelCmd = (holdLeft_q > 0 && srcSel_q == 2'h0) ? reqHeld_q : 3'h0;
	assign extIoCmd = (holdLeft_q > 0 && srcSel_q == 2'h1) ? reqHeld_q : 3'h0;
	assign hostCmd = (holdLeft_q > 0 && srcSel_q == 2'h2) ? reqHeld_q : 3'h0;
endmodule : scfc_operator_model

// ==== verification/scfc_supply_ctrl_sva.sv ====
// Purpose: port assertions for the supply command and fault controller
// Assumes: counts match the parameters handed on by the bind
// Notes: run counters see the levels at the pins, before any sync delay
`include "scfc_defines.svh"
module scfc_supply_ctrl_chk
	import scfc_pkg::*;
#(
	parameter int SoftStartCycles = 20,
	parameter int OvtQualCycles = 10,
	parameter int OctQualCycles = 15
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [`SCFC_LVL_W-1:0] outVoltage,
	input wire logic [`SCFC_LVL_W-1:0] outCurrent,
	input wire logic contactorClosed,
	input wire logic softStartActive,
	input wire logic powered,
	input wire logic standby,
	input wire logic alarm,
	input wire logic dissipativeOff,
	input wire scfc_fault_s faultStatus,
	input wire scfc_fault_s alarmOut,
	input wire logic [`SCFC_LVL_W-1:0] ovtThreshold,
	input wire logic [`SCFC_LVL_W-1:0] octThreshold
);
	int ovCnt_q;
	int ocCnt_q;
	int ssCnt_q;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// run lengths; a drop restarts them, so a glitch never adds up
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			ovCnt_q <= 0;
			ocCnt_q <= 0;
			ssCnt_q <= 0;
		end
		else
		begin
			ovCnt_q <= (outVoltage > ovtThreshold) ? ovCnt_q + 1 : 0;
			ocCnt_q <= (outCurrent > octThreshold) ? ocCnt_q + 1 : 0;
			ssCnt_q <= softStartActive ? ssCnt_q + 1 : 0;
		end

	// ----
	// assertions
	// ----
	contact_state_a: assert property (contactorClosed == (softStartActive || powered))
		else $error("contactor disagrees with state");
	trip_opens_a: assert property (alarm |-> !contactorClosed && !powered)
		else $error("contactor closed in alarm");
	standby_open_a: assert property (standby |-> !contactorClosed && !alarm)
		else $error("standby with contactor or alarm");
	start_gate_a: assert property ($rose(softStartActive) |-> $past(standby))
		else $error("soft start not from standby");
	soft_len_a: assert property ($rose(powered) |-> $past(softStartActive) &&
		ssCnt_q inside {[SoftStartCycles - 1:SoftStartCycles + 2]}) else $error("soft start length");
	fault_hold_a: assert property (faultStatus != 5'h00 |-> ##[0:2] alarm)
		else $error("latched fault without alarm");
	clear_exit_a: assert property ($fell(alarm) |-> standby)
		else $error("alarm left to other than standby");
	alarm_mirror_a: assert property (alarmOut == faultStatus)
		else $error("alarm outputs differ from status");
	thr_clamp_a: assert property (ovtThreshold <= 12'h999 && octThreshold <= 12'h999)
		else $error("threshold above limit");
	ovt_qual_a: assert property ($rose(faultStatus.overVoltageTrip) |->
		$past(ovCnt_q, 2) >= OvtQualCycles) else $error("voltage trip too early");
	oct_qual_a: assert property ($rose(faultStatus.overCurrentTrip) |->
		$past(ocCnt_q, 2) >= OctQualCycles) else $error("current trip too early");
	ilk_dissip_a: assert property (faultStatus.safetyInterlockFault |-> dissipativeOff)
		else $error("dissipative path still on");
	powered_c: cover property ($rose(powered));
	alarm_c: cover property ($rose(alarm));
	cleared_c: cover property ($fell(alarm));
endmodule : scfc_supply_ctrl_chk

bind scfc_supply_ctrl scfc_supply_ctrl_chk #(.SoftStartCycles(SoftStartCycles),
	.OvtQualCycles(OvtQualCycles), .OctQualCycles(OctQualCycles)) scfc_supply_ctrl_chk_i (
	.clock, .reset_n, .outVoltage, .outCurrent, .contactorClosed, .softStartActive, .powered,
	.standby, .alarm, .dissipativeOff, .faultStatus, .alarmOut, .ovtThreshold, .octThreshold);

// ==== verification/scfc_supply_ctrl_tb_top.sv ====
// Purpose: self-checking bench for the supply command and fault controller
// Assumes: short soft start and qualification counts keep the run brief
// Notes: commands reach the design through the operator model
module scfc_supply_ctrl_tb_top
	import scfc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SsCyc = 20;
	localparam int OvQual = 10;
	localparam int OcQual = 15;
	logic clock = 1'b0, reset_n = 1'b0, opGo = 1'b0;
	logic localCommandEnable = 1'b1, remoteCommandEnable = 1'b1;
	logic interlockEnable = 1'b1, interlockLevel = 1'b1, thermalSwitchOk = 1'b1;
	logic ovtSetValid = 1'b0, octSetValid = 1'b0;
	logic [11:0] phaseALevel = 12'hc00, outVoltage = 12'h010, outCurrent = 12'h010;
	logic [11:0] ovtSetValue = 12'h000, octSetValue = 12'h000, ovtThreshold, octThreshold;
	logic [1:0] opSrc = 2'h0;
	scfc_cmd_s opReq = 3'h0, panelCmd, extIoCmd, hostCmd;
	logic contactorClosed, softStartActive, powered, standby, alarm, dissipativeOff;
	scfc_fault_s faultStatus, alarmOut;
	int failCount = 0, nCompared = 0, cycles = 0;
	// columns: source, local enable, remote enable, contactor expected
	logic [4:0] rows [6] = '{5'h05, 5'h02, 5'h0b, 5'h0c, 5'h13, 5'h14};

	scfc_operator_model scfc_operator_model_i (.clock, .reset_n, .go(opGo), .src(opSrc),
		.req(opReq), .panelCmd, .extIoCmd, .hostCmd);
	scfc_supply_ctrl #(.SoftStartCycles(SsCyc), .OvtQualCycles(OvQual), .OctQualCycles(OcQual))
		scfc_supply_ctrl_i (.clock, .reset_n, .panelCmd, .extIoCmd, .hostCmd,
		.localCommandEnable, .remoteCommandEnable, .interlockEnable, .interlockLevel,
		.thermalSwitchOk, .phaseALevel, .outVoltage, .outCurrent, .ovtSetValid, .ovtSetValue,
		.octSetValid, .octSetValue, .contactorClosed, .softStartActive, .powered, .standby,
		.alarm, .dissipativeOff, .faultStatus, .alarmOut, .ovtThreshold, .octThreshold);

	// ----
	// helpers
	// ----
	initial
	begin
		forever #20 clock = ~clock;
	end

	task automatic tick();
		@(posedge clock);
		#2;
	endtask : tick

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			failCount++;
			$display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one request, then time for sync, state and output stages
	task automatic send(input logic [1:0] src, input scfc_cmd_s c);
		opSrc = src;
		opReq = c;
		opGo = 1'b1;
		tick();
		opGo = 1'b0;
		repeat (7) tick();
	endtask : send

	task automatic setThr(input logic [11:0] v);
		ovtSetValid = 1'b1;
		octSetValid = 1'b1;
		ovtSetValue = v;
		octSetValue = v;
		tick();
		ovtSetValid = 1'b0;
		octSetValid = 1'b0;
		repeat (2) tick();
	endtask : setThr

	// 0x132 sits just under a tenth of the rated line code
	task automatic setCond(input int k, input logic on);
		case (k)
			0: outVoltage = on ? 12'h200 : 12'h010;
			1: outCurrent = on ? 12'h200 : 12'h010;
			2: thermalSwitchOk = !on;
			3: interlockLevel = !on;
			default: phaseALevel = on ? 12'h132 : 12'hc00;
		endcase
	endtask : setCond

	task automatic endSim();
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : endSim

	// a hang counts as a mismatch
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failCount++;
			endSim();
		end
	end

	// ----
	// tests
	// ----
	initial
	begin
		repeat (3) tick();
		check("standby", standby, 1'b1);
		reset_n = 1'b1;
		repeat (2) tick();
		check("ovt default", ovtThreshold, 12'h999);
		check("oct default", octThreshold, 12'h999);
		$display("test reset done");
		foreach (rows[r])
		begin
			localCommandEnable = rows[r][2];
			remoteCommandEnable = rows[r][1];
			send(rows[r][4:3], 3'h4);
			check("start gated", contactorClosed, rows[r][0]);
			localCommandEnable = 1'b1;
			remoteCommandEnable = 1'b1;
			send(2'h1, 3'h2);
			check("stopped", standby, 1'b1);
			$display("test row %0d done", r);
		end
		send(2'h2, 3'h6);
		check("stop wins", contactorClosed, 1'b0);
		setThr(12'h100);
		check("ovt set", ovtThreshold, 12'h100);
		check("oct set", octThreshold, 12'h100);
		setThr(12'hfff);
		check("ovt clamp", ovtThreshold, 12'h999);
		check("oct clamp", octThreshold, 12'h999);
		setThr(12'h100);
		$display("test threshold done");
		for (int k = 0; k < 5; k++)
		begin
			send(2'h2, 3'h4);
			repeat (SsCyc) tick();
			check("powered", powered, 1'b1);
			if (k < 2)
			begin
				setCond(k, 1'b1);
				repeat (6) tick();
				setCond(k, 1'b0);
				repeat (6) tick();
				check("glitch", faultStatus, 12'h000);
			end
			setCond(k, 1'b1);
			repeat (OcQual + 8) tick();
			check("fault", faultStatus, 12'h010 >> k);
			check("alarm out", alarmOut, 12'h010 >> k);
			check("contactor", contactorClosed, 1'b0);
			if (k == 3)
				check("dissipative", dissipativeOff, 1'b1);
			send(2'h2, 3'h5);
			check("live clear", alarm, 1'b1);
			setCond(k, 1'b0);
			send(2'h2, 3'h1);
			check("cleared", standby, 1'b1);
			check("flags", faultStatus, 12'h000);
			$display("test fault %0d done", k);
		end
		// stop from the powered state, then interlock disarmed, then stop in alarm
		send(2'h2, 3'h4);
		repeat (SsCyc) tick();
		send(2'h0, 3'h2);
		check("stop powered", standby, 1'b1);
		check("stop opens", contactorClosed, 1'b0);
		interlockEnable = 1'b0;
		setCond(3, 1'b1);
		repeat (8) tick();
		check("ilk disarmed", faultStatus, 12'h000);
		check("ilk dissip", dissipativeOff, 1'b0);
		setCond(2, 1'b1);
		repeat (8) tick();
		send(2'h0, 3'h2);
		check("stop in alarm", alarm, 1'b1);
		// a mid-run reset stands for a control power cycle
		reset_n = 1'b0;
		setCond(2, 1'b0);
		setCond(3, 1'b0);
		tick();
		check("reset flags", faultStatus, 12'h000);
		reset_n = 1'b1;
		repeat (4) tick();
		check("reset standby", standby, 1'b1);
		check("reset no alarm", alarm, 1'b0);
		$display("test awkward done");
		endSim();
	end
endmodule : scfc_supply_ctrl_tb_top
